// *** verilog/accid_defs.vh ***
// Purpose: Constants of the accessory ID event registers
// Assumes: 100 MHz clock, 8-bit register data
// Notes:   Offsets are ULPI register addresses
`ifndef ACCID_DEFS_VH
`define ACCID_DEFS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ACCID_EN_WR       8'h1D
`define ACCID_EN_SET      8'h1E
`define ACCID_EN_CLR      8'h1F
`define ACCID_STATUS      8'h20
`define ACCID_LATCH       8'h21
`define ACCID_CONV_WR     8'h36
`define ACCID_CONV_SET    8'h37
`define ACCID_CONV_CLR    8'h38
`define ACCID_IMM_TOP     8'h3F

// ****************************************************************
// Field positions
// ****************************************************************
`define ACCID_EN_RISE     0
`define ACCID_EN_FALL     1
`define ACCID_EN_DONE     5
`define ACCID_ST_OPEN     0
`define ACCID_ST_CODE_LO  3
`define ACCID_ST_DONE     6
`define ACCID_LA_OPEN     0
`define ACCID_LA_DONE     3
`define ACCID_CV_DONE     3
`define ACCID_CV_START    4
`define ACCID_CV_IRQ_EN   6

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define ACCID_EN_MASK     8'h23
`define ACCID_CV_MASK     8'h70
`define ACCID_RST_BYTE    8'h00
`define ACCID_RST_CODE    3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ACCID_CLK_NS      10
`define ACCID_MEAS_NS     282000
`define ACCID_MEAS_CYC    ((`ACCID_MEAS_NS + `ACCID_CLK_NS - 1) / `ACCID_CLK_NS)

`endif

// *** verilog/accid_meas.v ***
// Purpose: ID resistance measurement sequencer
// Assumes: Converter result is stable when the run ends
// Notes:   A start while busy is ignored
`timescale 1ns/1ns
`include "accid_defs.vh"

module accid_meas #(
  parameter MEAS_CYCLES = `ACCID_MEAS_CYC,
  parameter CNT_W       = 15
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             start,
  input  wire [2:0]       code_in,
  output reg              busy,
  output reg              done,
  output reg  [2:0]       code
);

  reg  [CNT_W-1:0] count;

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      code  <= `ACCID_RST_CODE;
      count <= {CNT_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy  <= 1'b1;
          count <= MEAS_CYCLES[CNT_W-1:0] - 1'b1;
        end
      end else if (count == {CNT_W{1'b0}}) begin
        busy <= 1'b0;
        done <= 1'b1;
        code <= code_in;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // accid_meas

// *** verilog/accid_regs.v ***
// Purpose: Accessory ID event enable, status and latch registers
// Assumes: Register accesses arrive decoded from ULPI, one per cycle
// Notes:   alt_int feeds the alt_int bit of every RXCMD byte
//          Code bits of the conversion view are read-only here
//
// Function
// - Rising enable set: ID going floating raises alt_int.
// - Falling enable set: ID leaving floating raises alt_int.
// - Unimplemented accessory interrupt and DP bits always read zero.
// - Done enable raises alt_int on done; ORed with vendor enable.
// - Enable register reads 1Dh-1Fh; 1Dh writes, 1Eh sets, 1Fh clears.
// - Status bit 0 shows ID floating in real time.
// - Status bits 5:3 hold the measured resistance code.
// - Status bit 6 sets when a 282 us measurement finishes.
// - Done flag clears only on vendor conversion register read.
// - Status at 20h is read-only; writes ignored.
// - Latch at 21h is read-only and clears on read.
// - Latch bit 0 sets on an enabled floating edge.
// - Latch bit 3 sets on done rising while done interrupt enabled.
// - Addresses 00h-3Fh reachable by immediate or extended address.
// - Start bit begins measurement and clears itself at completion.
// - Vendor conversion register reads 36h-38h; write, set, clear.
`timescale 1ns/1ns
`include "accid_defs.vh"

module accid_regs #(
  parameter MEAS_CYCLES = `ACCID_MEAS_CYC
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire       reg_ext,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       id_open_in,
  input  wire [2:0] res_code_in,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  output reg        alt_int,
  output reg        meas_busy
);

  reg  [7:0] accessory_event_enable;
  reg  [7:0] conv_ctrl;
  reg  [7:0] accessory_event_latch;
  reg        id_open_now;
  reg        meas_done;
  reg        meas_done_q;
  wire [7:0] addr;
  wire [7:0] accessory_event_status;
  wire [7:0] conv_view;
  wire       busy;
  wire       done_pulse;
  wire [2:0] resistance_code;
  wire       meas_start;
  wire       id_rise;
  wire       id_fall;
  wire       done_rise;
  wire       rd_latch;
  wire       rd_conv;
  wire       wr_en_load;
  wire       wr_en_set;
  wire       wr_en_clr;
  wire       wr_cv_load;
  wire       wr_cv_set;
  wire       wr_cv_clr;
  reg  [7:0] next_enable;
  reg  [7:0] next_conv;
  reg  [7:0] next_latch;
  reg  [7:0] rd_mux;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function hit3;
    input [7:0] a;
    input [7:0] base;
    begin
      hit3 = (a == base) || (a == base + 8'h01) || (a == base + 8'h02);
    end
  endfunction

  // Immediate uses six bits; extended carries the full address
  assign addr = reg_ext ? reg_addr : {2'b00, reg_addr[5:0]};

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Writes to status, latch and unmapped addresses decode to nothing
  assign wr_en_load = reg_wr && addr == `ACCID_EN_WR;
  assign wr_en_set  = reg_wr && addr == `ACCID_EN_SET;
  assign wr_en_clr  = reg_wr && addr == `ACCID_EN_CLR;
  assign wr_cv_load = reg_wr && addr == `ACCID_CONV_WR;
  assign wr_cv_set  = reg_wr && addr == `ACCID_CONV_SET;
  assign wr_cv_clr  = reg_wr && addr == `ACCID_CONV_CLR;

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  accid_meas #(
    .MEAS_CYCLES (MEAS_CYCLES)
  ) u_meas (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (meas_start),
    .code_in (res_code_in),
    .busy    (busy),
    .done    (done_pulse),
    .code    (resistance_code)
  );

  // ****************************************************************
  // Register updates
  // ****************************************************************
  always @* begin
    next_enable = accessory_event_enable;
    if (wr_en_load)
      next_enable = reg_wdata & `ACCID_EN_MASK;
    else if (wr_en_set)
      next_enable = accessory_event_enable | (reg_wdata & `ACCID_EN_MASK);
    else if (wr_en_clr)
      next_enable = accessory_event_enable & ~reg_wdata;
  end

  always @* begin
    next_conv = conv_ctrl;
    if (done_pulse)
      next_conv[`ACCID_CV_START] = 1'b0;
    if (wr_cv_load)
      next_conv = reg_wdata & `ACCID_CV_MASK;
    else if (wr_cv_set)
      next_conv = next_conv | (reg_wdata & `ACCID_CV_MASK);
    else if (wr_cv_clr)
      next_conv = next_conv & ~reg_wdata;
  end

  // Start on a write or set that asserts the start bit
  // A start while busy is dropped; the stored bit still reads back
  assign meas_start = (wr_cv_load || wr_cv_set) && !busy &&
                      reg_wdata[`ACCID_CV_START];

  // Floating detection relies on the link enabling the ID pull-up
  assign id_rise   = id_open_in & ~id_open_now;
  assign id_fall   = ~id_open_in & id_open_now;
  assign done_rise = meas_done & ~meas_done_q;
  assign rd_latch  = reg_rd && addr == `ACCID_LATCH;
  assign rd_conv   = reg_rd && hit3(addr, `ACCID_CONV_WR);

  // Set wins over read-clear
  always @* begin
    next_latch = accessory_event_latch;
    if (rd_latch)
      next_latch = `ACCID_RST_BYTE;
    if ((id_rise && accessory_event_enable[`ACCID_EN_RISE]) ||
        (id_fall && accessory_event_enable[`ACCID_EN_FALL]))
      next_latch[`ACCID_LA_OPEN] = 1'b1;
    if (done_rise && (accessory_event_enable[`ACCID_EN_DONE] ||
                      conv_ctrl[`ACCID_CV_IRQ_EN]))
      next_latch[`ACCID_LA_DONE] = 1'b1;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      accessory_event_enable <= `ACCID_RST_BYTE;
      conv_ctrl              <= `ACCID_RST_BYTE;
      accessory_event_latch  <= `ACCID_RST_BYTE;
      id_open_now            <= 1'b0;
      meas_done              <= 1'b0;
      meas_done_q            <= 1'b0;
      alt_int                <= 1'b0;
      meas_busy              <= 1'b0;
    end else begin
      accessory_event_enable <= next_enable;
      conv_ctrl              <= next_conv;
      accessory_event_latch  <= next_latch;
      id_open_now            <= id_open_in;
      meas_done_q            <= meas_done;
      meas_busy              <= busy;
      if (done_pulse)
        meas_done <= 1'b1;
      else if (rd_conv)
        meas_done <= 1'b0;
      // Taken from next_latch so alt_int moves with the latch bits
      alt_int <= |next_latch;
    end
  end

  // ****************************************************************
  // Read views
  // ****************************************************************
  // Bits 1, 2 and 7 tie to zero
  assign accessory_event_status = {1'b0, meas_done, resistance_code,
                                   2'b00, id_open_now};
  assign conv_view = {1'b0, conv_ctrl[6:4], meas_done, resistance_code};

  always @* begin
    rd_mux = `ACCID_RST_BYTE;
    if (hit3(addr, `ACCID_EN_WR))
      rd_mux = accessory_event_enable & `ACCID_EN_MASK;
    else if (addr == `ACCID_STATUS)
      rd_mux = accessory_event_status;
    else if (addr == `ACCID_LATCH)
      rd_mux = accessory_event_latch;
    else if (hit3(addr, `ACCID_CONV_WR))
      rd_mux = conv_view;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata  <= `ACCID_RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

endmodule // accid_regs

// *** sim/aier_props.sv ***
// Purpose: Checker of the accessory ID event registers
// Assumes: Bound to accid_regs, small MEAS_CYCLES
// Notes:   Sees the top ports only
`timescale 1ns/1ns
module aier_props #(
  parameter MEAS_CYCLES = 8
) (
  input wire       clk,
  input wire       rst_n,
  input wire       reg_rd,
  input wire       reg_ext,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       reg_rvalid,
  input wire       alt_int,
  input wire       meas_busy
);
  wire [7:0]  eff = reg_ext ? reg_addr : {2'b00, reg_addr[5:0]};
  reg  [15:0] busy_cnt;
  always @(posedge clk) begin
    busy_cnt <= (!rst_n || !meas_busy) ? 16'h0000 : busy_cnt + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  status_resv_a: assert property (reg_rd && eff == 8'h20 |=> (reg_rdata & 8'h86) == 8'h00)
    else $error("status reserved bits set");
  enable_resv_a: assert property (reg_rd && eff >= 8'h1D && eff <= 8'h1F
    |=> (reg_rdata & 8'hDC) == 8'h00) else $error("enable reserved bits set");
  latch_resv_a: assert property (reg_rd && eff == 8'h21 |=> (reg_rdata & 8'hF6) == 8'h00)
    else $error("latch reserved bits set");
  unmapped_zero_a: assert property (reg_rd && eff > 8'h3F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  alt_hold_a: assert property (alt_int && !(reg_rd && eff == 8'h21) |=> alt_int)
    else $error("alt_int dropped without latch read");
  busy_long_a: assert property (meas_busy |-> busy_cnt < MEAS_CYCLES)
    else $error("measurement runs too long");
  busy_full_a: assert property ($fell(meas_busy) |-> $past(busy_cnt) == MEAS_CYCLES - 1)
    else $error("measurement ended early");
  cover property (reg_rd && eff == 8'h21 ##1 reg_rdata[0]);
  cover property ($rose(alt_int));
  cover property ($fell(meas_busy));
endmodule // aier_props
bind accid_regs aier_props #(.MEAS_CYCLES(MEAS_CYCLES)) props_u (.clk(clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_ext(reg_ext), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .alt_int(alt_int), .meas_busy(meas_busy));

// *** sim/aier_link.sv ***
// Purpose: Link controller model issuing register accesses
// Assumes: Answer comes one cycle after the read strobe
// Notes:   Released lines show inverted values
`timescale 1ns/1ns
module aier_link (
  input  wire       clk,
  input  wire [7:0] reg_rdata,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg        reg_ext,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_ext = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task acc(input w, input x, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_ext <= x;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(posedge clk);
      q = reg_rdata;
    end
  endtask
endmodule // aier_link

// *** sim/accessory_id_event_regs_bench.sv ***
// Purpose: Self-checking bench of the accessory ID event registers
// Assumes: MEAS_CYCLES shortened to 8
// Notes:   Link model issues all accesses
`timescale 1ns/1ns
module accessory_id_event_regs_bench;
  reg        clk = 1'b0;
  reg        rst_n, id_open_in;
  reg  [2:0] res_code_in;
  wire       reg_wr, reg_rd, reg_ext, reg_rvalid, alt_int, meas_busy;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  reg  [7:0] q;
  integer    err_count = 0, checks_done = 0, n;
  always #5 clk = ~clk;
  accid_regs #(.MEAS_CYCLES(8)) dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_ext(reg_ext), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .id_open_in(id_open_in), .res_code_in(res_code_in), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .alt_int(alt_int), .meas_busy(meas_busy));
  aier_link link_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_ext(reg_ext), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rdx(input x, input [7:0] a, input [7:0] e);
    begin
      link_u.acc(1'b0, x, a, 8'h00, q);
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(q, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    link_u.acc(1'b1, 1'b0, a, d, q);
  endtask
  task id_to(input v);
    begin
      @(posedge clk);
      id_open_in <= v;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task wait_busy(input lvl);
    begin
      n = 0;
      while (meas_busy !== lvl) begin
        @(posedge clk);
        #1 n = n + 1;
        if (n > 40) begin
          err_count = err_count + 1;
          disable scen;
        end
      end
    end
  endtask
  task t_reset;
    begin
      rdx(0, 8'h1D, 8'h00);
      rdx(0, 8'h20, 8'h00);
      rdx(0, 8'h21, 8'h00);
      rdx(0, 8'h36, 8'h00);
      $display("reset values done");
    end
  endtask
  task t_enable;
    begin
      wr(8'h1D, 8'hFF);
      rdx(0, 8'h1D, 8'h23);
      wr(8'h1F, 8'h01);
      rdx(0, 8'h1E, 8'h22);
      link_u.acc(1'b1, 1'b1, 8'h1E, 8'h01, q);
      rdx(1, 8'h1F, 8'h23);
      rdx(0, 8'hDD, 8'h23);
      rdx(1, 8'h40, 8'h00);
      $display("enable access done");
    end
  endtask
  task t_id;
    begin
      id_to(1'b1);
      chk({7'h00, alt_int}, 8'h01);
      wr(8'h20, 8'hFF);
      rdx(0, 8'h20, 8'h01);
      rdx(0, 8'h21, 8'h01);
      chk({7'h00, alt_int}, 8'h00);
      rdx(0, 8'h21, 8'h00);
      id_to(1'b0);
      chk({7'h00, alt_int}, 8'h01);
      rdx(0, 8'h21, 8'h01);
      wr(8'h1D, 8'h20);
      id_to(1'b1);
      id_to(1'b0);
      rdx(0, 8'h21, 8'h00);
      $display("id events done");
    end
  endtask
  task meas(input [7:0] en, input [7:0] sa, input [7:0] cv, input [2:0] code, input ex);
    begin
      @(posedge clk);
      res_code_in <= code;
      wr(8'h1D, en);
      wr(sa, cv);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (5) @(posedge clk);
      #1 chk({7'h00, alt_int}, {7'h00, ex});
      rdx(0, 8'h20, {2'b01, code, 3'b000});
      rdx(0, 8'h21, {4'h0, ex, 3'b000});
      rdx(0, 8'h20, {2'b01, code, 3'b000});
      rdx(0, 8'h36, {1'b0, cv[6], 3'b001, code});
      rdx(0, 8'h20, {2'b00, code, 3'b000});
      wr(8'h38, 8'h70);
      rdx(0, 8'h36, {5'h00, code});
      $display("measurement done");
    end
  endtask
  initial begin
    rst_n = 1'b0;
    id_open_in = 1'b0;
    res_code_in = 3'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    begin : scen
      t_reset;
      t_enable;
      t_id;
      meas(8'h20, 8'h36, 8'h10, 3'h5, 1'b1);
      meas(8'h00, 8'h36, 8'h50, 3'h7, 1'b1);
      meas(8'h00, 8'h37, 8'h10, 3'h2, 1'b0);
    end
    print_verdict;
  end
endmodule // accessory_id_event_regs_bench
